// [bpv_map.svh]
/*
  Register offsets, field positions, codes and reset values of the bus
  permission violation status block. Assumes a 32-bit byte-addressed
  register port with byte offsets, each register one aligned word.
*/
`ifndef BPV_MAP_SVH
`define BPV_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BPV_OFS_SUMMARY   8'h00
`define BPV_OFS_IRQ_STAT  8'h04
`define BPV_OFS_IRQ_MASK  8'h08
`define BPV_OFS_LOG_BASE  8'h40
`define BPV_LOG_STRIDE    8'h04

// ----------------------------------------------------------------------
// Log word fields
// ----------------------------------------------------------------------
`define BPV_LOG_MULTI_BIT 31
`define BPV_LOG_CODE_HI   27
`define BPV_LOG_CODE_LO   24
`define BPV_LOG_ID_HI     15
`define BPV_LOG_ID_LO     8

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define BPV_CODE_NONE     4'h0
`define BPV_CODE_PERM     4'h3
`define BPV_NUM_TARGETS   14
`define BPV_RST_WORD      32'h0000_0000

`endif

// [bpv_pkg.sv]
/*
  Types of the bus permission violation status block.
  Assumes bpv_map.svh is on the include path.
*/
package bpv_pkg;

  // ----------------------------------------------------------------------
  // Register port and violation report carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bpv_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] id;
  } bpv_report_t;

  typedef struct packed {
    logic       multi;
    logic [3:0] code;
    logic [7:0] id;
  } bpv_log_t;

endpackage

// [bpv_status.sv]
/*
  Bus permission violation status: per-target error logs, summary
  word, sticky interrupt status with mask.
  Assumes reports arrive from logic on the same clock, one-cycle pulses.
*/
// Chosen here: the register offsets and the plain strobed port.
// Overview of operation
// - Summary low 14 bits, one per target
// - Flag set once target reports; read-only, reset zero
// - Summary bits 31:14 read zero, writes ignored
// - Flags clear only via target log clear
// - Multi flag set on repeat, write-one clears
// - Code 0011 on violation, write-ones clear
// - Log holds read-only 8-bit requester identifier
`timescale 1ns/1ps
`include "bpv_map.svh"

module bpv_status #(
  parameter int NUM_TARGETS = `BPV_NUM_TARGETS
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  input  wire bpv_pkg::bpv_req_t      i_req,
  input  wire bpv_pkg::bpv_report_t   i_report [NUM_TARGETS],
  output logic [31:0]                 o_rdata,
  output logic                        o_irq
);
  import bpv_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // Summary word has room for at most 14 targets under this layout
  if (NUM_TARGETS < 1 || NUM_TARGETS > `BPV_NUM_TARGETS) begin : g_chk
    $error("NUM_TARGETS out of range");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] log_addr(input int idx);
    log_addr = 8'(`BPV_OFS_LOG_BASE + idx * `BPV_LOG_STRIDE);
  endfunction

  function automatic logic [31:0] pack_log(input bpv_log_t l);
    logic [31:0] w;
    w = `BPV_RST_WORD;
    w[`BPV_LOG_MULTI_BIT] = l.multi;
    w[`BPV_LOG_CODE_HI:`BPV_LOG_CODE_LO] = l.code;
    w[`BPV_LOG_ID_HI:`BPV_LOG_ID_LO] = l.id;
    pack_log = w;
  endfunction

  // ----------------------------------------------------------------------
  // Error logs
  // ----------------------------------------------------------------------
  bpv_log_t                  logs      [NUM_TARGETS];
  bpv_log_t                  next_logs [NUM_TARGETS];
  logic [NUM_TARGETS-1:0]    flags;
  logic [NUM_TARGETS-1:0]    new_evt;

  always_comb begin
    for (int t = 0; t < NUM_TARGETS; t++) begin
      next_logs[t] = logs[t];
      new_evt[t]   = 1'b0;
      // Write-one-to-clear of multi and code fields
      if (i_req.wr && i_req.addr == log_addr(t)) begin
        if (i_req.wdata[`BPV_LOG_MULTI_BIT]) begin
          next_logs[t].multi = 1'b0;
        end
        next_logs[t].code = logs[t].code &
                            ~i_req.wdata[`BPV_LOG_CODE_HI:`BPV_LOG_CODE_LO];
      end
      // Set beats a same-cycle clear of multi or of the whole code; a partial code clear still stands
      if (i_report[t].valid) begin
        new_evt[t] = 1'b1;
        if (logs[t].code != `BPV_CODE_NONE) begin
          // First error keeps its identity; later ones only mark repeat
          next_logs[t].multi = 1'b1;
        end
        if (next_logs[t].code == `BPV_CODE_NONE) begin
          next_logs[t].code = `BPV_CODE_PERM;
          next_logs[t].id   = i_report[t].id;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int t = 0; t < NUM_TARGETS; t++) begin
      if (i_srst) begin
        logs[t] <= '0;
      end else begin
        logs[t] <= next_logs[t];
      end
    end
  end

  // Flag follows the log directly, so clearing the log drops it
  always_comb begin
    for (int t = 0; t < NUM_TARGETS; t++) begin
      flags[t] = (logs[t].code != `BPV_CODE_NONE);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  logic [NUM_TARGETS-1:0] irq_stat;
  logic [NUM_TARGETS-1:0] irq_mask;
  logic [NUM_TARGETS-1:0] next_irq_stat;
  logic [NUM_TARGETS-1:0] next_irq_mask;
  logic                   next_irq;

  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (i_req.wr && i_req.addr == `BPV_OFS_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~i_req.wdata[NUM_TARGETS-1:0];
    end
    if (i_req.wr && i_req.addr == `BPV_OFS_IRQ_MASK) begin
      next_irq_mask = i_req.wdata[NUM_TARGETS-1:0];
    end
    next_irq_stat = next_irq_stat | new_evt;
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_stat <= '0;
      irq_mask <= '0;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      o_irq    <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = `BPV_RST_WORD;
    if (i_req.rd) begin
      case (i_req.addr)
        `BPV_OFS_SUMMARY:  next_rdata[NUM_TARGETS-1:0] = flags;
        `BPV_OFS_IRQ_STAT: next_rdata[NUM_TARGETS-1:0] = irq_stat;
        `BPV_OFS_IRQ_MASK: next_rdata[NUM_TARGETS-1:0] = irq_mask;
        default: begin
          for (int t = 0; t < NUM_TARGETS; t++) begin
            if (i_req.addr == log_addr(t)) begin
              next_rdata = pack_log(logs[t]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= `BPV_RST_WORD;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_summary_upper_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    $past(i_req.rd) && $past(i_req.addr) == `BPV_OFS_SUMMARY |-> o_rdata[31:NUM_TARGETS] == '0)
    else $error("summary upper bits not zero");

  a_summary_matches: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == `BPV_OFS_SUMMARY |=> o_rdata[NUM_TARGETS-1:0] == $past(flags))
    else $error("summary read mismatch");

  a_report_sets_code: assert property (@(posedge i_clk) disable iff (i_srst)
    i_report[0].valid |=> logs[0].code == `BPV_CODE_PERM)
    else $error("code not set on violation");

  a_flag_follows: assert property (@(posedge i_clk) disable iff (i_srst)
    i_report[0].valid |=> flags[0])
    else $error("flag not raised on report");

  a_flag_only_clr: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(flags[0]) |-> $past(i_req.wr) && $past(i_req.addr) == log_addr(0))
    else $error("flag fell without log clear");

  a_clear_drops: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.wr && i_req.addr == log_addr(0)
    && i_req.wdata[`BPV_LOG_CODE_HI:`BPV_LOG_CODE_LO] == 4'hF && !i_report[0].valid
    |=> !flags[0])
    else $error("flag stays after clear");

  a_multi_sets: assert property (@(posedge i_clk) disable iff (i_srst)
    flags[0] && i_report[0].valid |=> logs[0].multi)
    else $error("repeat not flagged");

  a_id_captured: assert property (@(posedge i_clk) disable iff (i_srst)
    !flags[0] && i_report[0].valid |=> logs[0].id == $past(i_report[0].id))
    else $error("requester id not captured");

  // ----------------------------------------------------------------------
  // Summary word assertions
  // ----------------------------------------------------------------------
  a_summary_from_logs: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == `BPV_OFS_SUMMARY
    |=> o_rdata[0] == ($past(logs[0].code) != `BPV_CODE_NONE))
    else $error("summary bit zero disagrees with log");

  a_summary_top_bit: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == `BPV_OFS_SUMMARY
    |=> o_rdata[NUM_TARGETS-1] == ($past(logs[NUM_TARGETS-1].code) != `BPV_CODE_NONE))
    else $error("summary top bit disagrees with log");

  a_flag_top_raise: assert property (@(posedge i_clk) disable iff (i_srst)
    i_report[NUM_TARGETS-1].valid |=> flags[NUM_TARGETS-1])
    else $error("top flag not raised on report");

  a_flag_stays: assert property (@(posedge i_clk) disable iff (i_srst)
    flags[0] && !(i_req.wr && i_req.addr == log_addr(0)) |=> flags[0])
    else $error("flag dropped without log write");

  a_flag_top_stays: assert property (@(posedge i_clk) disable iff (i_srst)
    flags[NUM_TARGETS-1] && !(i_req.wr && i_req.addr == log_addr(NUM_TARGETS-1))
    |=> flags[NUM_TARGETS-1])
    else $error("top flag dropped without log write");

  a_summary_ro: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.wr && i_req.addr == `BPV_OFS_SUMMARY |=> (flags & $past(flags)) == $past(flags))
    else $error("summary write disturbed flags");

  // ----------------------------------------------------------------------
  // Error log assertions
  // ----------------------------------------------------------------------
  a_log_gaps_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == log_addr(0)
    |=> o_rdata[30:28] == 3'h0 && o_rdata[23:16] == 8'h00 && o_rdata[7:0] == 8'h00)
    else $error("unused log bits not zero");

  a_multi_clears: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.wr && i_req.addr == log_addr(0) && i_req.wdata[`BPV_LOG_MULTI_BIT]
    && !i_report[0].valid |=> !logs[0].multi)
    else $error("repeat flag not cleared by write");

  a_multi_holds: assert property (@(posedge i_clk) disable iff (i_srst)
    logs[0].multi && !(i_req.wr && i_req.addr == log_addr(0)
    && i_req.wdata[`BPV_LOG_MULTI_BIT]) |=> logs[0].multi)
    else $error("repeat flag lost without write");

  a_multi_needs_code: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(logs[0].multi) |-> $past(flags[0]) && $past(i_report[0].valid))
    else $error("repeat flag without earlier error");

  a_multi_top_sets: assert property (@(posedge i_clk) disable iff (i_srst)
    flags[NUM_TARGETS-1] && i_report[NUM_TARGETS-1].valid |=> logs[NUM_TARGETS-1].multi)
    else $error("top repeat not flagged");

  a_multi_read: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == log_addr(0)
    |=> o_rdata[`BPV_LOG_MULTI_BIT] == $past(logs[0].multi))
    else $error("repeat flag read mismatch");

  a_code_read: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == log_addr(0)
    |=> o_rdata[`BPV_LOG_CODE_HI:`BPV_LOG_CODE_LO] == $past(logs[0].code))
    else $error("code read mismatch");

  a_top_code_read: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == log_addr(NUM_TARGETS-1)
    |=> o_rdata[`BPV_LOG_CODE_HI:`BPV_LOG_CODE_LO] == $past(logs[NUM_TARGETS-1].code))
    else $error("top code read mismatch");

  a_code_w1c: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.wr && i_req.addr == log_addr(0) && !i_report[0].valid
    |=> logs[0].code == ($past(logs[0].code)
        & ~$past(i_req.wdata[`BPV_LOG_CODE_HI:`BPV_LOG_CODE_LO])))
    else $error("code bits not cleared by ones");

  a_code_no_set: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_report[0].valid |=> (logs[0].code & ~$past(logs[0].code)) == 4'h0)
    else $error("code bits set without report");

  a_top_code_set: assert property (@(posedge i_clk) disable iff (i_srst)
    i_report[NUM_TARGETS-1].valid |=> logs[NUM_TARGETS-1].code == `BPV_CODE_PERM)
    else $error("top code not set on violation");

  a_id_read: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == log_addr(0)
    |=> o_rdata[`BPV_LOG_ID_HI:`BPV_LOG_ID_LO] == $past(logs[0].id))
    else $error("requester id read mismatch");

  a_top_id_read: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.rd && i_req.addr == log_addr(NUM_TARGETS-1)
    |=> o_rdata[`BPV_LOG_ID_HI:`BPV_LOG_ID_LO] == $past(logs[NUM_TARGETS-1].id))
    else $error("top requester id read mismatch");

  a_id_kept: assert property (@(posedge i_clk) disable iff (i_srst)
    flags[0] && !(i_req.wr && i_req.addr == log_addr(0)) |=> $stable(logs[0].id))
    else $error("requester id changed while logged");

  a_id_ro: assert property (@(posedge i_clk) disable iff (i_srst)
    i_req.wr && i_req.addr == log_addr(0) && !i_report[0].valid |=> $stable(logs[0].id))
    else $error("requester id written by software");

  a_id_top_captured: assert property (@(posedge i_clk) disable iff (i_srst)
    !flags[NUM_TARGETS-1] && i_report[NUM_TARGETS-1].valid
    |=> logs[NUM_TARGETS-1].id == $past(i_report[NUM_TARGETS-1].id))
    else $error("top requester id not captured");

endmodule

// [bpv_target_model.sv]
/*
  Far-side model: fourteen bus targets raising violation reports.
  Assumes the bench drives the fire mask just after a rising edge.
*/
`timescale 1ns/1ps
module bpv_target_model #(
  parameter int N = 14
) (
  input  wire logic [N-1:0]    i_fire,
  input  wire logic [7:0]      i_id,
  output bpv_pkg::bpv_report_t o_report [N]
);
  import bpv_pkg::*;
  // ----------------------------------------------------------------
  // Report drive
  // ----------------------------------------------------------------
  // Idle id shows the inverse, so a stale id never looks captured
  always_comb begin
    for (int t = 0; t < N; t++) begin
      o_report[t].valid = i_fire[t];
      o_report[t].id    = i_fire[t] ? i_id : ~i_id;
    end
  end
endmodule

// [bpv_status_tb_top.sv]
/*
  Self-checking bench of the violation status block.
  Assumes bpv_map.svh on the include path and the target model.
*/
`timescale 1ns/1ps
`include "bpv_map.svh"
module bpv_status_tb_top;
  import bpv_pkg::*;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  logic        i_clk;
  logic        i_srst;
  bpv_req_t    i_req;
  bpv_report_t rep [14];
  logic [13:0] fire;
  logic [7:0]  rid;
  logic [31:0] o_rdata;
  logic        o_irq;
  int          fails;
  int          n_checks;
  int          cyc = 0;
  localparam logic [7:0] L0  = `BPV_OFS_LOG_BASE;
  localparam logic [7:0] L13 = `BPV_OFS_LOG_BASE + 8'h34;

  bpv_status #(.NUM_TARGETS(14)) dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req),
    .i_report(rep), .o_rdata(o_rdata), .o_irq(o_irq));
  bpv_target_model #(.N(14)) far_u (.i_fire(fire), .i_id(rid), .o_report(rep));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) i_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk) i_req.wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk) i_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge i_clk) i_req.rd <= 1'b0;
    #1 check(o_rdata, e);
  endtask

  task automatic pulse(input logic [13:0] m, input logic [7:0] id);
    @(posedge i_clk) begin
      fire <= m;
      rid  <= id;
    end
    @(posedge i_clk) fire <= 14'h0000;
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge i_clk);
    #1 check({31'h0, o_irq}, {31'h0, e});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(`BPV_OFS_SUMMARY, `BPV_RST_WORD);
    rd(`BPV_OFS_IRQ_STAT, `BPV_RST_WORD);
    rd(L13, `BPV_RST_WORD);
  endtask

  task automatic t_flags;
    pulse(14'h2001, 8'h05);
    rd(`BPV_OFS_SUMMARY, 32'h0000_2001);
    rd(L13, 32'h0300_0500);
    wr(`BPV_OFS_SUMMARY, 32'hFFFF_FFFF);
    rd(`BPV_OFS_SUMMARY, 32'h0000_2001);
    rd(8'hFC, 32'h0000_0000);
  endtask

  // Second report keeps the first id and only marks a repeat
  task automatic t_multi;
    pulse(14'h2001, 8'hA5);
    rd(L0, 32'h8300_0500);
    rd(L13, 32'h8300_0500);
    wr(L0, 32'h0000_FF00);
    rd(L0, 32'h8300_0500);
    wr(L0, 32'h8000_0000);
    rd(L0, 32'h0300_0500);
    wr(L0, 32'h0100_0000);
    rd(L0, 32'h0200_0500);
    rd(`BPV_OFS_SUMMARY, 32'h0000_2001);
    wr(L0, 32'h0F00_0000);
    rd(`BPV_OFS_SUMMARY, 32'h0000_2000);
  endtask

  task automatic t_irq;
    irq_is(1'b0);
    wr(`BPV_OFS_IRQ_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wr(`BPV_OFS_IRQ_STAT, 32'h0000_0001);
    irq_is(1'b0);
    rd(`BPV_OFS_IRQ_STAT, 32'h0000_2000);
  endtask

  // Mid-run reset held three edges so no stale flag looks like a fall
  task automatic t_midreset;
    @(posedge i_clk) i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(`BPV_OFS_SUMMARY, `BPV_RST_WORD);
    rd(L13, `BPV_RST_WORD);
    rd(`BPV_OFS_IRQ_MASK, `BPV_RST_WORD);
    irq_is(1'b0);
    pulse(14'h0020, 8'h3C);
    rd(8'h54, 32'h0300_3C00);
  endtask

  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs about 75 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      finish_test;
    end
  end

  initial begin
    i_srst = 1'b1;
    i_req = '0;
    fire = 14'h0000;
    rid = 8'h00;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset;
    t_flags;
    t_multi;
    t_irq;
    t_midreset;
    finish_test;
  end
endmodule
